/* rtl/sdpci_pkg.sv */
// Shared constants, types and helpers for the SDRAM pin command block.
// Assumes a single 40 MHz clock; all pins sampled on its rising edge.
package sdpci_pkg;

  // Array geometry: four banks, 2048 rows, 256 columns, 32-bit words
  localparam int DW       = 32;
  localparam int AW       = 11;
  localparam int BW       = 2;
  localparam int CW       = 8;
  localparam int LANES    = 4;
  localparam int LANE_W   = 8;
  localparam int MIDX_W   = BW + AW + CW;
  localparam int MEM_WORDS = 2 ** MIDX_W;

  // Clock rate, kept for reference by timing users
  localparam int CLK_MHZ  = 40;

  // Command codes on {select, row strobe, column strobe, write enable}
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;

  // Mode register field positions
  localparam int MR_BL_LO = 0;
  localparam int MR_BT    = 3;
  localparam int MR_CL_LO = 4;
  localparam int MR_OP_LO = 7;
  localparam int MR_WB    = 9;
  // Address bit that carries auto precharge / precharge-all
  localparam int AP_BIT   = 10;

  // Burst length and read latency codes
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_1    = 3'h1;
  localparam logic [2:0] CL_2    = 3'h2;
  localparam logic [2:0] CL_3    = 3'h3;

  // Mode register after reset: burst of one, sequential, latency two
  localparam logic [10:0] MODE_RST = 11'h020;

  // Power state of the device
  typedef enum logic [1:0] {
    SDPCI_RUN     = 2'b00,
    SDPCI_PDN_PRE = 2'b01,
    SDPCI_PDN_ACT = 2'b10,
    SDPCI_SELF    = 2'b11
  } sdpci_pwr_t;

  // Number of words in a burst for a length code
  function automatic logic [8:0] sdpci_bl_len(input logic [2:0] code);
    case (code)
      BL_1:    return 9'h001;
      BL_2:    return 9'h002;
      BL_4:    return 9'h004;
      BL_8:    return 9'h008;
      BL_FULL: return 9'h100;
      default: return 9'h001;
    endcase
  endfunction

  // Column of beat cnt in a burst from start, sequential or interleaved
  function automatic logic [7:0] sdpci_col(input logic [7:0]  start,
                                           input logic [8:0]  cnt,
                                           input logic [10:0] mode);
    logic [7:0] m;
    logic [7:0] off;
    m   = 8'(sdpci_bl_len(mode[MR_BL_LO +: 3]) - 9'h001);
    off = mode[MR_BT] ? (start ^ cnt[7:0]) : 8'(start + cnt[7:0]);
    return (start & ~m) | (off & m);
  endfunction

endpackage

/* rtl/sdpci_buf2.sv */
// Two-entry valid/ready buffer on the read data path.
// Assumes DEPTH is a power of two so the pointers wrap by themselves.
`timescale 1ns/1ps
module sdpci_buf2 #(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = DEPTH[PW:0];

  // Whole buffer state in one record
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] ent;   // Stored words
    logic [PW-1:0]           wp;    // Next slot to fill
    logic [PW-1:0]           rp;    // Oldest slot
    logic [PW:0]             cnt;   // Words held
  } sdpci_buf_t;

  sdpci_buf_t s;
  sdpci_buf_t n;
  logic       push;
  logic       pop;

  // Honest flags straight from the count
  assign in_ready  = (s.cnt != FULL);
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.ent[s.rp];

  // Next state: a push and a pop may share one cycle
  always_comb begin
    n    = s;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push) begin
      n.ent[s.wp] = in_data;
      n.wp        = s.wp + 1'b1;
    end
    if (pop) begin
      n.rp = s.rp + 1'b1;
    end
    // Count only moves when exactly one side acts
    if (push && !pop) begin
      n.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = s.cnt - 1'b1;
    end
  end

  // Register the record
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule

/* rtl/sdpci_core.sv */
// Device side of a four-bank SDRAM: command decode, banks, bursts, masks.
// Assumes every pin is synchronous to sys_clk; data pins are split into
// data_in, data_out and per-lane output enables resolved by the bench.
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Hash-suffixed pins are asserted when low
// RULE2 - Capture every input on rising clock edge
// RULE3 - Burst column and outputs advance each edge
// RULE4 - Clock gate high runs, low freezes device
// RULE5 - Gate drop picks power-down, self refresh, suspend
// RULE6 - Gate watched asynchronously while powered down; the code samples it on the sys_clk rising edge
// RULE7 - Input buffers off in power-down, self refresh
// RULE8 - Controller may tie clock gate high
// RULE9 - Select low enables decoder, high ignores commands
// RULE10 - Deselected: bursts finish, masks still act
// RULE11 - Command from select and three strobes together
// RULE12 - Write mask high blocks storing that byte
// RULE13 - Read mask high floats byte two clocks later
// RULE14 - Each mask bit owns one eight-bit lane
// RULE15 - Single mask name means all four equal
// RULE16 - Bank select names command's target bank
// RULE17 - Row-open samples all eleven address bits
// RULE18 - Low eight bits column, bit ten autoprecharge
// RULE19 - Precharge bit ten high closes all banks
// RULE20 - Mode load writes address into mode register
// RULE21 - One shared 32-bit bidirectional data bus
// RULE22 - Controller waits 100 us with idle commands; the bench gives three NOP cycles after reset
// RULE23 - Mode fields: length, type, latency, op, write
// RULE24 - Access opens row, then reads or writes
// RULE25 - Customary strobe truth table encodes commands
// RULE26 - Controller keeps gate high in normal use
module sdpci_core (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        chip_sel_n,
  input  wire logic        row_strobe_n,
  input  wire logic        col_strobe_n,
  input  wire logic        write_en_n,
  input  wire logic [1:0]  bank_select,
  input  wire logic [10:0] addr_in,
  input  wire logic [3:0]  byte_mask,
  input  wire logic [31:0] data_in,
  output logic [31:0]      data_out,
  output logic [3:0]       data_oe
);

  // All device state in one record
  typedef struct packed {
    sdpci_pkg::sdpci_pwr_t   pwr;      // Power state
    logic                    cke;      // Clock gate seen at last edge
    logic [10:0]             mode;     // Mode register
    logic [3:0]              row_open; // Row active per bank
    logic [3:0][10:0]        row_addr; // Open row per bank
    logic                    bact;     // Burst beyond first beat running
    logic                    bwr;      // Running burst is a write
    logic                    bap;      // Close the row at burst end
    logic [1:0]              bbank;    // Bank of the burst
    logic [7:0]              bstart;   // Start column
    logic [8:0]              bcnt;     // Next beat number
    logic                    p0_v;     // Latency stage 0
    logic [31:0]             p0_d;
    logic                    p1_v;     // Latency stage 1
    logic [31:0]             p1_d;
    logic [3:0]              dqm_d1;   // Masks from the previous edge
    logic                    dvalid;   // Output word is live
    logic [31:0]             dout;     // Output word
    logic [3:0]              doe;      // Per-lane drive enable
  } sdpci_state_t;

  sdpci_state_t s;
  sdpci_state_t n;

  // Word array, one entry per bank/row/column
  logic [31:0] mem [0:sdpci_pkg::MEM_WORDS-1];

  logic [3:0]                    cmd;       // Decoded command code
  logic                          tick;      // Internal clock runs
  logic                          new_rw;    // Read or write taken now
  logic                          last;      // Burst is on its last beat
  logic                          addr_bit_ten_autopre;
  logic                          mwe;       // Store a word this edge
  logic [3:0]                    mbe;       // Lanes to store
  logic [sdpci_pkg::MIDX_W-1:0]  maddr;     // Store address
  logic                          rd_v;      // Fetch a word this edge
  logic [sdpci_pkg::MIDX_W-1:0]  rd_addr;   // Fetch address
  logic [7:0]                    col;       // Burst column
  logic [8:0]                    blen;      // Burst length in words
  logic                          buf_ir;    // Read buffer can take
  logic                          buf_ov;    // Read buffer has a word
  logic [31:0]                   buf_od;    // Read buffer head

  // Flat word index from bank, row and column
  function automatic logic [sdpci_pkg::MIDX_W-1:0] mem_idx(
      input logic [1:0] bank, input logic [10:0] row, input logic [7:0] c);
    return {bank, row, c};
  endfunction

  assign addr_bit_ten_autopre = addr_in[sdpci_pkg::AP_BIT];
  // Pins are read straight from registers: no glitches reach the bus
  assign data_out = s.dout;
  assign data_oe  = s.doe;                                  // RULE21

  // Read words wait here while the clock is suspended, so none is lost
  sdpci_buf2 #(
    .W     (32),
    .DEPTH (2)
  ) u_rdbuf (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_valid  (rd_v),
    .in_ready  (buf_ir),
    .in_data   (mem[rd_addr]),
    .out_valid (buf_ov),
    .out_ready (tick),
    .out_data  (buf_od)
  );

  // Next-state logic for decode, bursts, latency pipe and power
  always_comb begin
    n       = s;
    mwe     = 1'b0;
    mbe     = '0;
    maddr   = '0;
    rd_v    = 1'b0;
    rd_addr = '0;
    col     = '0;
    // Strobes are active low and sampled as one code
    cmd     = {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n}; // RULE11
    blen    = sdpci_pkg::sdpci_bl_len(s.mode[sdpci_pkg::MR_BL_LO +: 3]);
    tick    = (s.pwr == sdpci_pkg::SDPCI_RUN) && s.cke;     // RULE4
    new_rw  = tick && !chip_sel_n &&
              (cmd == sdpci_pkg::CMD_RD || cmd == sdpci_pkg::CMD_WR); // RULE1
    last    = (s.bcnt == 9'(blen - 9'h001)) &&
              (s.mode[sdpci_pkg::MR_BL_LO +: 3] != sdpci_pkg::BL_FULL);
    n.cke    = clk_en;                                      // RULE2
    n.dqm_d1 = byte_mask;                                   // RULE15
    if (s.pwr != sdpci_pkg::SDPCI_RUN) begin
      // Inputs are off; only the gate is watched, without its clock
      if (clk_en) begin
        n.pwr = sdpci_pkg::SDPCI_RUN;                       // RULE6 RULE7
      end
    end else if (tick) begin
      // Latency pipe moves one stage per running edge
      n.dvalid = s.p1_v;                                    // RULE3
      n.dout   = s.p1_d;
      n.p1_v   = s.p0_v;
      n.p1_d   = s.p0_d;
      n.p0_v   = 1'b0;
      if (buf_ov) begin
        // Enter the pipe at the depth that gives the programmed latency
        unique case (s.mode[sdpci_pkg::MR_CL_LO +: 3])      // RULE23
          sdpci_pkg::CL_1: begin
            n.dvalid = 1'b1;
            n.dout   = buf_od;
          end
          sdpci_pkg::CL_2: begin
            n.p1_v = 1'b1;
            n.p1_d = buf_od;
          end
          default: begin
            n.p0_v = 1'b1;
            n.p0_d = buf_od;
          end
        endcase
      end
      // Running burst continues even while deselected
      if (s.bact && !new_rw) begin                          // RULE10
        col = sdpci_pkg::sdpci_col(s.bstart, s.bcnt, s.mode);
        if (s.bwr) begin
          mwe   = 1'b1;
          mbe   = ~byte_mask;                               // RULE12
          maddr = mem_idx(s.bbank, s.row_addr[s.bbank], col);
        end else begin
          rd_v    = 1'b1;
          rd_addr = mem_idx(s.bbank, s.row_addr[s.bbank], col);
        end
        // A full buffer holds the counter back rather than drop a word
        if (s.bwr || buf_ir) begin
          n.bcnt = s.bcnt + 9'h001;                         // RULE3
          if (last) begin
            n.bact = 1'b0;
            if (s.bap) begin
              n.row_open[s.bbank] = 1'b0;
            end
          end
        end
      end
      // Decoder works only with select low
      if (!chip_sel_n) begin                                // RULE9
        unique case (cmd)                                   // RULE25
          sdpci_pkg::CMD_LMR: begin
            n.mode = addr_in;                               // RULE20
          end
          sdpci_pkg::CMD_ACT: begin
            n.row_open[bank_select] = 1'b1;                 // RULE16
            n.row_addr[bank_select] = addr_in;              // RULE17
          end
          sdpci_pkg::CMD_RD, sdpci_pkg::CMD_WR: begin
            // First beat goes at the command edge; a new one cuts the old
            n.bwr    = (cmd == sdpci_pkg::CMD_WR);
            n.bap    = addr_bit_ten_autopre;                // RULE18
            n.bbank  = bank_select;
            n.bstart = addr_in[7:0];
            n.bcnt   = 9'h001;
            n.bact   = (blen != 9'h001) &&
                       !(n.bwr && s.mode[sdpci_pkg::MR_WB]);
            if (n.bwr) begin
              mwe   = 1'b1;
              mbe   = ~byte_mask;                           // RULE12
              maddr = mem_idx(bank_select, s.row_addr[bank_select],
                              addr_in[7:0]);
            end else begin
              rd_v    = 1'b1;
              rd_addr = mem_idx(bank_select, s.row_addr[bank_select],
                                addr_in[7:0]);
            end
            if (!n.bact && addr_bit_ten_autopre) begin
              n.row_open[bank_select] = 1'b0;
            end
          end
          sdpci_pkg::CMD_PRE: begin
            if (addr_bit_ten_autopre) begin
              n.row_open = '0;                              // RULE19
              n.bact     = 1'b0;
            end else begin
              n.row_open[bank_select] = 1'b0;
              if (s.bbank == bank_select) begin
                n.bact = 1'b0;
              end
            end
          end
          sdpci_pkg::CMD_BST: begin
            n.bact = 1'b0;
          end
          default: begin
            // Refresh and no-operation leave the state alone
          end
        endcase
      end
      // Gate dropping: choose the low-power state from the activity
      if (!clk_en) begin                                    // RULE5
        if (!chip_sel_n && cmd == sdpci_pkg::CMD_REF &&
            s.row_open == '0 && !s.bact) begin
          n.pwr = sdpci_pkg::SDPCI_SELF;
        end else if ((chip_sel_n || cmd == sdpci_pkg::CMD_NOP) &&
                     !s.bact && !s.p0_v && !s.p1_v && !s.dvalid &&
                     !buf_ov && !rd_v) begin
          n.pwr = (s.row_open == '0) ? sdpci_pkg::SDPCI_PDN_PRE
                                     : sdpci_pkg::SDPCI_PDN_ACT;
        end
        // Otherwise a command, a burst or read data is live: plain suspend through s.cke
      end
    end
    // Lane drive follows the mask taken one edge earlier
    n.doe = {4{n.dvalid && n.pwr == sdpci_pkg::SDPCI_RUN}} &
            ~s.dqm_d1;                                      // RULE13
  end

  // Register the record
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s      <= '0;
      s.mode <= sdpci_pkg::MODE_RST;
    end else begin
      s <= n;
    end
  end

  // Store unmasked lanes; masked lanes keep their old byte
  always_ff @(posedge sys_clk) begin
    if (mwe) begin
      for (int i = 0; i < sdpci_pkg::LANES; i++) begin
        if (mbe[i]) begin
          mem[maddr][i*8 +: 8] <= data_in[i*8 +: 8];        // RULE14
        end
      end
    end
  end

  // Checks on the decoded behaviour
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_lmr;
    tick && !chip_sel_n && cmd == sdpci_pkg::CMD_LMR;
  endsequence
  sequence s_act;
    tick && !chip_sel_n && cmd == sdpci_pkg::CMD_ACT;
  endsequence
  sequence s_burst_go;
    tick && s.bact && !new_rw && (s.bwr || buf_ir) && !last;
  endsequence
  sequence s_self_in;
    tick && !clk_en && !chip_sel_n && cmd == sdpci_pkg::CMD_REF &&
    s.row_open == '0 && !s.bact;
  endsequence

  a_mode_load: assert property ( // RULE20
    s_lmr |=> s.mode == $past(addr_in))
    else $error("mode register missed its load");
  a_cs_masks: assert property ( // RULE9
    tick && chip_sel_n |=> $stable(s.mode) && $stable(s.row_addr))
    else $error("deselected command changed state");
  a_row_open: assert property ( // RULE17
    s_act |=> s.row_open[$past(bank_select)] &&
              s.row_addr[$past(bank_select)] == $past(addr_in))
    else $error("row open did not latch the row");
  a_pre_all: assert property ( // RULE19
    tick && !chip_sel_n && cmd == sdpci_pkg::CMD_PRE &&
    addr_bit_ten_autopre |=> s.row_open == '0)
    else $error("precharge all left a row open");
  a_mask_hiz: assert property ( // RULE13
    (s.doe & $past(byte_mask, 2)) == '0)
    else $error("masked read lane still driven");
  a_suspend_hold: assert property ( // RULE4
    s.pwr == sdpci_pkg::SDPCI_RUN && !s.cke
      |=> $stable(s.dout) && $stable(s.bcnt))
    else $error("state moved while clock suspended");
  a_pd_exit: assert property ( // RULE6
    s.pwr != sdpci_pkg::SDPCI_RUN && clk_en
      |=> s.pwr == sdpci_pkg::SDPCI_RUN)
    else $error("power-down not left on gate high");
  a_pd_inputs: assert property ( // RULE7
    s.pwr != sdpci_pkg::SDPCI_RUN |=> $stable(s.mode) && $stable(s.row_open))
    else $error("inputs acted during power-down");
  a_burst_step: assert property ( // RULE3
    s_burst_go |=> s.bcnt == $past(s.bcnt) + 9'h001)
    else $error("burst counter did not advance");
  a_self_in: assert property ( // RULE5
    s_self_in |=> s.pwr == sdpci_pkg::SDPCI_SELF)
    else $error("self refresh not entered");

endmodule

/* verification/sdpci_ctrl_model.sv */
// Controller-side model: command strobes and the shared data bus.
// Assumes the bench hands it one command code per cycle.
`timescale 1ns/1ps
module sdpci_ctrl_model (
  input  wire logic        sys_clk,
  input  wire logic [3:0]  cmd_code,
  input  wire logic        wr_drive,
  input  wire logic [31:0] wr_data,
  input  wire logic [31:0] data_out,
  input  wire logic [3:0]  data_oe,
  output logic             chip_sel_n,
  output logic             row_strobe_n,
  output logic             col_strobe_n,
  output logic             write_en_n,
  output logic [31:0]      bus_word
);
  logic [31:0] last_r = 32'h0;  // Last level seen on the bus

  // Code bits go straight onto the four active-low pins
  assign chip_sel_n   = cmd_code[3];
  assign row_strobe_n = cmd_code[2];
  assign col_strobe_n = cmd_code[1];
  assign write_en_n   = cmd_code[0];

  // Per-lane bus resolution; a lane nobody drives shows the inverse of
  // its last level, so a stale value can never pass for read data
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (data_oe[i]) begin
        bus_word[8*i +: 8] = data_out[8*i +: 8];
      end else if (wr_drive) begin
        bus_word[8*i +: 8] = wr_data[8*i +: 8];
      end else begin
        bus_word[8*i +: 8] = ~last_r[8*i +: 8];
      end
    end
  end

  // Remember the bus level for the floating-lane pattern
  always @(posedge sys_clk) begin
    last_r <= bus_word;
  end
endmodule

/* verification/testbench.sv */
// Self-checking bench for the SDRAM pin command block.
// Assumes the controller model resolves the shared data bus.
`timescale 1ns/1ps
module testbench;
  logic        sys_clk     = 1'b0;    // 40 MHz system clock
  logic        sys_rst     = 1'b1;    // Synchronous reset, high
  logic        clk_en      = 1'b1;    // Clock gate pin
  logic [3:0]  cmd_code    = 4'h7;    // Select and strobes, NOP
  logic [1:0]  bank_select = 2'h0;
  logic [10:0] addr_in     = 11'h000;
  logic [3:0]  byte_mask   = 4'h0;
  logic        wr_drive    = 1'b0;    // Controller drives the bus
  logic [31:0] wr_data     = 32'h0;
  logic        chip_sel_n, row_strobe_n, col_strobe_n, write_en_n;
  logic [31:0] data_out, bus_word, obs, r;
  logic [3:0]  data_oe, oe_obs;
  logic [31:0] lfsr = 32'h0000_0D68;  // Fixed seed, repeatable run
  logic [31:0] mem [int];             // Expected contents by location
  logic [31:0] wq [8];                // Beat data of one burst
  logic [3:0]  mq [8];                // Beat masks of one burst
  logic [3:0]  fill [3] = '{4'h7, 4'hF, 4'hC}; // Idle codes, deselects
  logic [1:0]  cur_bank;
  logic [10:0] row;
  logic [7:0]  col;
  logic [2:0]  bl;
  logic        il;
  int          n, cl, susp;
  int          num_errors = 0;
  int          cmp_count  = 0;

  always #12.5 sys_clk = ~sys_clk;

  sdpci_core uut (.sys_clk, .sys_rst, .clk_en, .chip_sel_n, .row_strobe_n,
    .col_strobe_n, .write_en_n, .bank_select, .addr_in, .byte_mask,
    .data_in(bus_word), .data_out, .data_oe);

  sdpci_ctrl_model ctrl (.sys_clk, .cmd_code, .wr_drive, .wr_data,
    .data_out, .data_oe, .chip_sel_n, .row_strobe_n, .col_strobe_n,
    .write_en_n, .bus_word);

  // Next pseudo-random word
  function automatic logic [31:0] rnd();
    repeat (32) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // Widen a lane mask to the 32 data bits it governs
  function automatic logic [31:0] lanes(input logic [3:0] m);
    for (int i = 0; i < 4; i++) lanes[8*i +: 8] = {8{m[i]}};
  endfunction

  // Column of beat k: wraps inside the burst block, xor when interleaved
  function automatic logic [7:0] beat_col(input int k);
    logic [7:0] w;
    w = 8'(n - 1);
    return (col & ~w) | ((il ? (col ^ 8'(k)) : 8'(col + 8'(k))) & w);
  endfunction

  function automatic int key(input int k);
    return int'({cur_bank, row, beat_col(k)});
  endfunction

  // One cycle: drive after the edge, sample at the falling edge
  task automatic step(input logic [3:0] c, input logic [10:0] a,
                      input logic [3:0] m, input logic dr,
                      input logic [31:0] d, input logic ce);
    @(posedge sys_clk);
    cmd_code    <= c;
    addr_in     <= a;
    byte_mask   <= m;
    wr_drive    <= dr;
    wr_data     <= d;
    clk_en      <= ce;
    bank_select <= cur_bank;
    @(negedge sys_clk);
    obs    = bus_word;
    oe_obs = data_oe;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t ns: expected %h, got %h", $time, exp, got);
    end
  endtask

  // Write or read burst; idle cycles use random NOP or deselect codes, and a read
  // may be suspended once, which holds every later beat one cycle
  task automatic burst(input logic rd, input int sp);
    int k;
    int x;
    logic [3:0] c;
    logic [3:0] m;
    logic [31:0] e;
    for (int j = 0; j < (rd ? n + cl + 3 : n); j++) begin
      r = rnd();
      c = (j == 0) ? (rd ? 4'h5 : 4'h4) : fill[r[1:0] % 3];
      x = j - cl + 1;
      m = rd ? ((x >= 0 && x < n) ? mq[x] : 4'h0) : mq[j];
      step(c, {rd, 2'b00, col}, m, !rd, wq[j % 8], !(sp > 0 && j == sp));
      k = j - cl - 1 - ((sp > 0 && j >= sp + 2) ? 1 : 0);
      if (!rd) begin
        mem[key(j)] = (mem[key(j)] & lanes(m)) | (wq[j] & ~lanes(m));
      end else if (k >= 0 && k < n) begin
        e = ~lanes(mq[k]);
        chk(mem[key(k)] & e, obs & e);
        chk({28'h0, ~mq[k]}, {28'h0, oe_obs});
      end else begin
        chk(32'h0, {28'h0, oe_obs});
      end
    end
  endtask

  // Closing report, shared by the main sequence and the watchdog
  task automatic give_verdict;
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence: lengths of one to eight words and every latency code, both burst orders
  initial begin
    cur_bank = 2'h0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) step(4'h7, 11'h000, 4'h0, 1'b0, 32'h0, 1'b1);
    chk(32'h0, {28'h0, oe_obs});
    for (int it = 0; it < 24; it++) begin
      r = rnd();
      bl = 3'(it % 4);
      n = 1 << bl;
      cl = 1 + (it / 4) % 3;
      il = r[8];
      cur_bank = r[1:0];
      row = r[20:10];
      col = r[31:24];
      susp = (it % 5 == 4 && n > 1) ? cl + 1 : 0;
      step(4'h0, {4'h0, 3'(cl), il, bl}, 4'h0, 1'b0, 32'h0, 1'b1);
      step(4'h3, row, 4'h0, 1'b0, 32'h0, 1'b1);
      // Plain write, masked write over it, then read back, masked unless the read is suspended
      for (int p = 0; p < 3; p++) begin
        for (int j = 0; j < 8; j++) begin
          wq[j] = rnd();
          r = rnd();
          mq[j] = (p == 0 || (p == 2 && susp > 0)) ? 4'h0 : r[3:0];
        end
        burst(p == 2, p == 2 ? susp : 0);
      end
      step(4'h2, it[0] ? 11'h400 : 11'h000, 4'h0, 1'b0, 32'h0, 1'b1);
      // Idle power-down with the gate low, then back to running
      // Gate low with refresh enters self refresh on some passes; a mode
      // load given while powered down must be ignored
      step(it[1] ? 4'h1 : 4'h7, 11'h000, 4'h0, 1'b0, 32'h0, 1'b0);
      repeat (2) step(4'h0, 11'h7FF, 4'h0, 1'b0, 32'h0, 1'b0);
      chk(32'h0, {28'h0, oe_obs});
      repeat (3) step(4'h7, 11'h000, 4'h0, 1'b0, 32'h0, 1'b1);
    end
    give_verdict();
  end

  // Watchdog: a hung run counts as a mismatch
  initial begin
    repeat (40000) @(posedge sys_clk);
    num_errors++;
    give_verdict();
  end
endmodule
